// File: oag_pkg.sv
/*
 Constants, register map and field layout for the operand address generator.
 Assumes a single 10 MHz clock domain and an Avalon-MM slave with 32-bit data.
*/
package oag_pkg;
   // -----------------------------------------------------------------
   // Register map (byte offsets)
   // -----------------------------------------------------------------
   localparam logic [4:0] OFF_CTRL = 5'h00;
   localparam logic [4:0] OFF_PC   = 5'h04;
   localparam logic [4:0] OFF_REGS = 5'h08;
   localparam logic [4:0] OFF_OP   = 5'h0C;
   localparam logic [4:0] OFF_RES  = 5'h10;
   localparam logic [4:0] OFF_AUX  = 5'h14;
   // -----------------------------------------------------------------
   // Control field positions and reset values
   // -----------------------------------------------------------------
   localparam int unsigned CTRL_BEF_POS  = 0;
   localparam int unsigned CTRL_BSR_LSB  = 4;
   localparam int unsigned CTRL_SBS_LSB  = 8;
   localparam int unsigned SBS_MODE_BIT  = 3;
   localparam int unsigned SBS_BANK_BIT  = 0;
   localparam logic        BEF_RESET     = 1'b0;
   localparam logic [3:0]  BSR_RESET     = 4'h0;
   localparam logic [3:0]  SBS_RESET     = 4'h8;
   localparam logic [13:0] PC_RESET      = 14'h0000;
   localparam logic [31:0] REGS_RESET    = 32'h0000_0000;
   localparam logic [31:0] OP_RESET      = 32'h0000_0000;
   // -----------------------------------------------------------------
   // Operation word field positions
   // -----------------------------------------------------------------
   localparam int unsigned OP_KIND_LSB   = 16;
   localparam int unsigned OP_PORT_LSB   = 24;
   localparam int unsigned OP_SKIP_LSB   = 28;
   // -----------------------------------------------------------------
   // Operand kinds
   // -----------------------------------------------------------------
   localparam logic [4:0] K_DIRECT    = 5'h00;
   localparam logic [4:0] K_DIRECT8   = 5'h01;
   localparam logic [4:0] K_IND_DE    = 5'h02;
   localparam logic [4:0] K_IND_DL    = 5'h03;
   localparam logic [4:0] K_FMEM      = 5'h04;
   localparam logic [4:0] K_PMEM_L    = 5'h05;
   localparam logic [4:0] K_BLOCK     = 5'h06;
   localparam logic [4:0] K_SHORT     = 5'h07;
   localparam logic [4:0] K_VECTOR    = 5'h08;
   localparam logic [4:0] K_EXTENDED  = 5'h09;
   localparam logic [4:0] K_REL       = 5'h0A;
   localparam logic [4:0] K_TBL_BCDE  = 5'h0B;
   localparam logic [4:0] K_TBL_BCXA  = 5'h0C;
   localparam logic [4:0] K_TBL_PC_DE_INDIRECT  = 5'h0D;
   localparam logic [4:0] K_TBL_PCXA  = 5'h0E;
   localparam logic [4:0] K_BR_PC_DE_INDIRECT   = 5'h0F;
   localparam logic [4:0] K_BR_PCXA   = 5'h10;
   localparam logic [4:0] K_STACK     = 5'h11;
   // -----------------------------------------------------------------
   // Banks and address limits
   // -----------------------------------------------------------------
   localparam logic [3:0]  BANK0       = 4'h0;
   localparam logic [3:0]  BANK1       = 4'h1;
   localparam logic [3:0]  BANK15      = 4'hF;
   localparam logic [3:0]  FMEM_HI_A   = 4'hB;
   localparam logic [3:0]  FMEM_HI_B   = 4'hF;
   localparam logic [7:0]  PMEM_MIN    = 8'hC0;
   localparam logic [13:0] TADDR_MIN   = 14'h0020;
   localparam logic [13:0] TADDR_MAX   = 14'h007F;
   localparam logic [13:0] REL_FWD_MIN = 14'h0002;
   localparam logic [13:0] REL_FWD_MAX = 14'h0010;
   localparam logic [13:0] REL_BACK_MIN = 14'h3FF1;
   localparam logic [15:0] PORT_MASK   = 16'h036F;
   localparam logic [1:0]  LONG_BYTES  = 2'h3;
   localparam logic [1:0]  SKIP_SHORT  = 2'h1;
   localparam logic [1:0]  SKIP_LONG   = 2'h2;
   // -----------------------------------------------------------------
   // Bus handshake states
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_ACK = 2'b10} oag_bus_state_t;
endpackage

// File: oag_operand_address_gen.sv
/*
 Operand address generator: data-memory bank/address and program-memory target
 formation, legality flags and skip cost, with registers over Avalon-MM.
 Assumes one clock, a synchronous active-high reset and a master that holds
 each request until it samples waitrequest low.
*/
// The placing of the registers and the Avalon-MM register port were decided locally.
`timescale 1ns/1ns
`default_nettype none

module oag_operand_address_gen
   import oag_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        srst_i,
   input  wire logic [4:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   output logic      [11:0] dmem_addr_o,
   output logic      [1:0]  dmem_bit_o,
   output logic             dmem_ok_o,
   output logic      [13:0] pmem_addr_o,
   output logic             pmem_ok_o,
   output logic      [1:0]  skip_cycles_o,
   output logic             port_ok_o,
   output logic             stack_bank_o,
   output logic             legacy_mode_o
);
   import oag_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   oag_bus_state_t state;
   oag_bus_state_t next_state;
   logic           next_waitrequest;
   logic [31:0]    next_readdata;
   logic           bank_enable_flag;
   logic [3:0]     bank_select_reg;
   logic [3:0]     sbs;
   logic [13:0]    pc;
   logic [31:0]    regs;
   logic [31:0]    op;
   logic           next_bank_enable_flag;
   logic [3:0]     next_bank_select_reg;
   logic [3:0]     next_sbs;
   logic [13:0]    next_pc;
   logic [31:0]    next_regs;
   logic [31:0]    next_op;
   logic [11:0]    next_dmem_addr;
   logic [1:0]     next_dmem_bit;
   logic           next_dmem_ok;
   logic [13:0]    next_pmem_addr;
   logic           next_pmem_ok;
   logic [1:0]     next_skip;
   logic           next_port_ok;
   logic [31:0]    ctrl_word;
   logic [31:0]    wr_merged;
   logic           wr_take;
   logic [3:0]     reg_a, reg_x, reg_l, reg_h, reg_e, reg_d, reg_c, reg_b;
   logic [15:0]    operand;
   logic [4:0]     kind;
   logic [3:0]     port_num;
   logic [1:0]     skip_bytes;
   logic [3:0]     active_bank;
   logic           extended_mode;
   logic [13:0]    rel_diff;
   logic [14:0]    four_reg_ptr;

   // Register fields and operation word fields
   assign reg_a       = regs[3:0];
   assign reg_x       = regs[7:4];
   assign reg_l       = regs[11:8];
   assign reg_h       = regs[15:12];
   assign reg_e       = regs[19:16];
   assign reg_d       = regs[23:20];
   assign reg_c       = regs[27:24];
   assign reg_b       = regs[31:28];
   assign operand     = op[15:0];
   assign kind        = op[OP_KIND_LSB +: 5];
   assign port_num    = op[OP_PORT_LSB +: 4];
   assign skip_bytes  = op[OP_SKIP_LSB +: 2];
   assign extended_mode = ~sbs[SBS_MODE_BIT];
   assign ctrl_word   = {20'h00000, sbs, bank_select_reg, 3'h0, bank_enable_flag};
   assign wr_take     = (state == ST_ACK) && avs_write_i;

   // Byte-lane merge of write data into the addressed register
   function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  be);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (be[i])
         begin
            res[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return res;
   endfunction

   // ----------------------------------------------------------------
   // Bus handshake
   // ----------------------------------------------------------------
   // Idle holds waitrequest high; a request is answered in the next cycle
   always_comb
   begin
      next_state       = state;
      next_waitrequest = 1'b1;
      case (state)
         ST_IDLE:
         begin
            if (avs_read_i || avs_write_i)
            begin
               next_state       = ST_ACK;
               next_waitrequest = 1'b0;
            end
         end
         ST_ACK:
         begin
            next_state = ST_IDLE;
         end
         default:
         begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // Read data latched as the answer cycle starts; unmapped reads give zero
   always_comb
   begin
      next_readdata = avs_readdata_o;
      if ((state == ST_IDLE) && avs_read_i)
      begin
         case (avs_address_i)
            OFF_CTRL: next_readdata = ctrl_word;
            OFF_PC:   next_readdata = {18'h00000, pc};
            OFF_REGS: next_readdata = regs;
            OFF_OP:   next_readdata = op;
            OFF_RES:  next_readdata = {1'b0, next_pmem_ok, next_pmem_addr, 1'b0,
                                       next_dmem_ok, next_dmem_bit, next_dmem_addr};
            OFF_AUX:  next_readdata = {26'h0000000, sbs[SBS_BANK_BIT], next_port_ok,
                                       2'h0, next_skip};
            default:  next_readdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         state             <= ST_IDLE;
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o    <= 32'h0000_0000;
      end
      else
      begin
         state             <= next_state;
         avs_waitrequest_o <= next_waitrequest;
         avs_readdata_o    <= next_readdata;
      end
   end

   // ----------------------------------------------------------------
   // Software registers
   // ----------------------------------------------------------------
   // Writes land at the edge where waitrequest is seen low
   always_comb
   begin
      next_bank_enable_flag = bank_enable_flag;
      next_bank_select_reg  = bank_select_reg;
      next_sbs              = sbs;
      next_pc               = pc;
      next_regs             = regs;
      next_op               = op;
      wr_merged             = 32'h0000_0000;
      if (wr_take)
      begin
         case (avs_address_i)
            OFF_CTRL:
            begin
               wr_merged             = be_merge(ctrl_word, avs_writedata_i, avs_byteenable_i);
               next_bank_enable_flag = wr_merged[CTRL_BEF_POS];
               next_bank_select_reg  = wr_merged[CTRL_BSR_LSB +: 4];
               next_sbs              = wr_merged[CTRL_SBS_LSB +: 4];
            end
            OFF_PC:
            begin
               wr_merged = be_merge({18'h00000, pc}, avs_writedata_i, avs_byteenable_i);
               next_pc   = wr_merged[13:0];
            end
            OFF_REGS: next_regs = be_merge(regs, avs_writedata_i, avs_byteenable_i);
            OFF_OP:   next_op   = be_merge(op, avs_writedata_i, avs_byteenable_i);
            default:  next_op   = op;
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         bank_enable_flag <= BEF_RESET;
         bank_select_reg  <= BSR_RESET;
         sbs              <= SBS_RESET;
         pc               <= PC_RESET;
         regs             <= REGS_RESET;
         op               <= OP_RESET;
      end
      else
      begin
         bank_enable_flag <= next_bank_enable_flag;
         bank_select_reg  <= next_bank_select_reg;
         sbs              <= next_sbs;
         pc               <= next_pc;
         regs             <= next_regs;
         op               <= next_op;
      end
   end

   // ----------------------------------------------------------------
   // Address generation
   // ----------------------------------------------------------------
   // Bank for direct operands from the enable flag and bank select
   always_comb
   begin
      if (!bank_enable_flag)
      begin
         active_bank = operand[7] ? BANK15 : BANK0;
      end
      else
      begin
         active_bank = bank_select_reg;
      end
   end

   assign rel_diff     = operand[13:0] - pc;
   assign four_reg_ptr = {reg_b[2:0], reg_c, reg_d, reg_e};

   // Decode the operand word into addresses, legality and skip cost
   always_comb
   begin
      next_dmem_addr = 12'h000;
      next_dmem_bit  = operand[9:8];
      next_dmem_ok   = 1'b0;
      next_pmem_addr = 14'h0000;
      next_pmem_ok   = 1'b0;
      case (kind)
         K_DIRECT, K_DIRECT8:
         begin
            next_dmem_addr = {active_bank, operand[7:0]};
            next_dmem_ok   = (active_bank == BANK0) || (active_bank == BANK1) ||
                             (active_bank == BANK15);
            if (kind == K_DIRECT8)
            begin
               next_dmem_ok = next_dmem_ok && !operand[0];
            end
         end
         K_IND_DE:
         begin
            next_dmem_addr = {BANK0, reg_d, reg_e};
            next_dmem_ok   = 1'b1;
         end
         K_IND_DL:
         begin
            next_dmem_addr = {BANK0, reg_d, reg_l};
            next_dmem_ok   = 1'b1;
         end
         K_FMEM:
         begin
            next_dmem_addr = {BANK15, operand[7:0]};
            next_dmem_ok   = (operand[7:4] == FMEM_HI_A) || (operand[7:4] == FMEM_HI_B);
         end
         K_PMEM_L:
         begin
            next_dmem_addr = {BANK15, operand[7:2], reg_l[3:2]};
            next_dmem_bit  = reg_l[1:0];
            next_dmem_ok   = (operand[7:0] >= PMEM_MIN);
         end
         K_STACK:
         begin
            next_dmem_addr = {3'h0, sbs[SBS_BANK_BIT], operand[7:0]};
            next_dmem_ok   = 1'b1;
         end
         K_BLOCK:
         begin
            next_pmem_addr = {pc[13:12], operand[11:0]};
            next_pmem_ok   = 1'b1;
         end
         K_SHORT:
         begin
            next_pmem_addr = {3'h0, operand[10:0]};
            next_pmem_ok   = 1'b1;
         end
         K_VECTOR:
         begin
            next_pmem_addr = operand[13:0];
            next_pmem_ok   = (operand[13:0] >= TADDR_MIN) && (operand[13:0] <= TADDR_MAX) &&
                             !operand[0];
         end
         K_EXTENDED:
         begin
            next_pmem_addr = operand[13:0];
            next_pmem_ok   = extended_mode;
         end
         K_REL:
         begin
            next_pmem_addr = operand[13:0];
            next_pmem_ok   = ((rel_diff >= REL_FWD_MIN) && (rel_diff <= REL_FWD_MAX)) ||
                             (rel_diff >= REL_BACK_MIN);
         end
         K_TBL_BCDE:
         begin
            next_pmem_addr = four_reg_ptr[13:0];
            next_pmem_ok   = !four_reg_ptr[14];
         end
         K_TBL_BCXA:
         begin
            next_pmem_addr = {reg_b[1:0], reg_c, reg_x, reg_a};
            next_pmem_ok   = !reg_b[2];
         end
         K_TBL_PC_DE_INDIRECT:
         begin
            next_pmem_addr = {pc[13:8], reg_d, reg_e};
            next_pmem_ok   = 1'b1;
         end
         K_TBL_PCXA:
         begin
            next_pmem_addr = {pc[13:8], reg_x, reg_a};
            next_pmem_ok   = 1'b1;
         end
         K_BR_PC_DE_INDIRECT:
         begin
            next_pmem_addr = {pc[13:8], reg_d, reg_e};
            next_pmem_ok   = 1'b1;
         end
         K_BR_PCXA:
         begin
            next_pmem_addr = {pc[13:8], reg_x, reg_a};
            next_pmem_ok   = 1'b1;
         end
         default:
         begin
            next_dmem_ok = 1'b0;
         end
      endcase
   end

   assign next_skip    = (skip_bytes == LONG_BYTES) ? SKIP_LONG : SKIP_SHORT;
   assign next_port_ok = PORT_MASK[port_num];

   // Registered decode results and mode outputs
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         dmem_addr_o   <= 12'h000;
         dmem_bit_o    <= 2'h0;
         dmem_ok_o     <= 1'b0;
         pmem_addr_o   <= 14'h0000;
         pmem_ok_o     <= 1'b0;
         skip_cycles_o <= SKIP_SHORT;
         port_ok_o     <= 1'b0;
         stack_bank_o  <= SBS_RESET[SBS_BANK_BIT];
         legacy_mode_o <= SBS_RESET[SBS_MODE_BIT];
      end
      else
      begin
         dmem_addr_o   <= next_dmem_addr;
         dmem_bit_o    <= next_dmem_bit;
         dmem_ok_o     <= next_dmem_ok;
         pmem_addr_o   <= next_pmem_addr;
         pmem_ok_o     <= next_pmem_ok;
         skip_cycles_o <= next_skip;
         port_ok_o     <= next_port_ok;
         stack_bank_o  <= next_sbs[SBS_BANK_BIT];
         legacy_mode_o <= next_sbs[SBS_MODE_BIT];
      end
   end

endmodule

`default_nettype wire

// File: oag_checker.sv
/*
 Bus and result checks on the ports of the operand address generator.
 Assumes one clock and the synchronous active-high reset of the design.
*/
`timescale 1ns/1ns
`default_nettype none
module oag_checker
(
   input wire logic        clk_i,
   input wire logic        srst_i,
   input wire logic [4:0]  avs_address_i,
   input wire logic        avs_read_i,
   input wire logic        avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0]  avs_byteenable_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic        avs_waitrequest_o,
   input wire logic [11:0] dmem_addr_o,
   input wire logic        dmem_ok_o,
   input wire logic        pmem_ok_o,
   input wire logic [1:0]  skip_cycles_o,
   input wire logic        port_ok_o,
   input wire logic        stack_bank_o,
   input wire logic        legacy_mode_o
);
   localparam logic [15:0] PORTS_OK = 16'h036F;
   // ---------------------------------------------------------------
   // Sequences and assertions
   // ---------------------------------------------------------------
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (srst_i);
   // Accepted writes to the control and operation words
   sequence s_ctrl_wr;
      avs_write_i && !avs_waitrequest_o && avs_address_i == 5'h00 && avs_byteenable_i[1];
   endsequence
   sequence s_op_wr;
      avs_write_i && !avs_waitrequest_o && avs_address_i == 5'h0C && avs_byteenable_i[3];
   endsequence
   a_answer_next: assert property ($rose(avs_read_i || avs_write_i) |=> !avs_waitrequest_o)
      else $error("bus answer late");
   a_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low too long");
   a_rdata_hold: assert property ($changed(avs_readdata_o) |-> avs_read_i && !avs_waitrequest_o)
      else $error("read data moved outside an answer");
   a_reset_vals: assert property (disable iff (1'b0) srst_i |=> legacy_mode_o && skip_cycles_o == 2'h1)
      else $error("reset values wrong");
   a_mode_follow: assert property (s_ctrl_wr |-> ##2 legacy_mode_o == $past(avs_writedata_i[11], 2))
      else $error("stack mode bit not applied");
   a_stack_bank: assert property (s_ctrl_wr |-> ##2 stack_bank_o == $past(avs_writedata_i[8], 2))
      else $error("stack bank not applied");
   a_skip_cost: assert property (s_op_wr |-> ##2 skip_cycles_o ==
      (($past(avs_writedata_i[29:28], 2) == 2'h3) ? 2'h2 : 2'h1))
      else $error("skip cost wrong");
   a_port_map: assert property (s_op_wr |-> ##2 port_ok_o == PORTS_OK[$past(avs_writedata_i[27:24], 2)])
      else $error("port validity wrong");
   a_bank_legal: assert property (dmem_ok_o |-> dmem_addr_o[11:8] inside {4'h0, 4'h1, 4'hF})
      else $error("legal access in unknown bank");
   a_ok_excl: assert property (!(dmem_ok_o && pmem_ok_o))
      else $error("data and program flags both set");
endmodule

bind oag_operand_address_gen oag_checker u_chk (.clk_i(clk_i), .srst_i(srst_i),
   .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
   .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
   .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
   .dmem_addr_o(dmem_addr_o), .dmem_ok_o(dmem_ok_o), .pmem_ok_o(pmem_ok_o),
   .skip_cycles_o(skip_cycles_o), .port_ok_o(port_ok_o), .stack_bank_o(stack_bank_o),
   .legacy_mode_o(legacy_mode_o));
`default_nettype wire

// File: oag_host.sv
/*
 Avalon-MM master model for the software side of the register bus.
 Assumes it is called right after a rising clock edge.
*/
`timescale 1ns/1ns
`default_nettype none
module oag_host
(
   input  wire logic        clk_i,
   input  wire logic        wait_i,
   input  wire logic [31:0] rdata_i,
   output var  logic [4:0]  addr_o,
   output var  logic        rd_o,
   output var  logic        wr_o,
   output var  logic [31:0] wdata_o,
   output var  logic [3:0]  be_o
);
   // Idle bus at time zero
   initial
   begin
      addr_o  = 5'h00;
      rd_o    = 1'b0;
      wr_o    = 1'b0;
      wdata_o = 32'h0;
      be_o    = 4'hF;
   end

   // One transfer, held until waitrequest is sampled low
   task automatic xfer(input logic wr, input logic [4:0] a, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] q);
      addr_o  <= a;
      rd_o    <= !wr;
      wr_o    <= wr;
      wdata_o <= d;
      be_o    <= be;
      // Only the bench watchdog ends a wait that never gets an answer
      do
      begin
         @(posedge clk_i);
      end
      while (wait_i);
      q = rdata_i;
      rd_o <= 1'b0;
      wr_o <= 1'b0;
      @(posedge clk_i); // Gap before the next request
   endtask
endmodule
`default_nettype wire

// File: oag_operand_address_gen_test.sv
/*
 Self-checking bench for the operand address generator.
 Assumes the package, host model and checker are compiled before it.
*/
`timescale 1ns/1ns
`default_nettype none
module oag_operand_address_gen_test;
   import oag_pkg::*;
   typedef struct packed
   {
      logic [11:0] ctl;
      logic [13:0] pc;
      logic [31:0] rg;
      logic [31:0] op;
      logic [31:0] res;
      logic [1:0]  m;
   } oag_row_t;
   // ---------------------------------------------------------------
   // Cases: control, PC, registers, operation, result, mask code
   // ---------------------------------------------------------------
   localparam oag_row_t ROWS [32] = '{
      {12'h800, 14'h0, 32'h0, 32'h1000007F, 32'h407F, 2'd0},
      {12'h800, 14'h0, 32'h0, 32'h10000380, 32'h7F80, 2'd0},
      {12'h811, 14'h0, 32'h0, 32'h100000A5, 32'h41A5, 2'd0},
      {12'h8F1, 14'h0, 32'h0, 32'h10010033, 32'h0F33, 2'd0},
      {12'h8F1, 14'h0, 32'hA50000, 32'h10020000, 32'h40A5, 2'd0},
      {12'h8F1, 14'h0, 32'hA00C00, 32'h10030000, 32'h40AC, 2'd0},
      {12'h811, 14'h0, 32'h0, 32'h100402B7, 32'h6FB7, 2'd0},
      {12'h811, 14'h0, 32'h0, 32'h100400C3, 32'h0FC3, 2'd0},
      {12'h800, 14'h0, 32'hB00, 32'h100500E4, 32'h7FE6, 2'd0},
      {12'h800, 14'h0, 32'h0, 32'h100500BC, 32'h0FBC, 2'd0},
      {12'h800, 14'h3456, 32'h0, 32'h3006F123, 32'h71230000, 2'd1},
      {12'h800, 14'h0, 32'h0, 32'h20070FFF, 32'h47FF0000, 2'd1},
      {12'h800, 14'h0, 32'h0, 32'h10080020, 32'h40200000, 2'd1},
      {12'h800, 14'h0, 32'h0, 32'h10080021, 32'h00210000, 2'd1},
      {12'h800, 14'h0, 32'h0, 32'h10080080, 32'h00800000, 2'd1},
      {12'h800, 14'h0, 32'h0, 32'h10093FFF, 32'h3FFF0000, 2'd1},
      {12'h000, 14'h0, 32'h0, 32'h10093FFF, 32'h7FFF0000, 2'd1},
      {12'h800, 14'h10, 32'h0, 32'h100A0001, 32'h40010000, 2'd1},
      {12'h800, 14'h10, 32'h0, 32'h100A0000, 32'h00000000, 2'd1},
      {12'h800, 14'h10, 32'h0, 32'h100A0011, 32'h00110000, 2'd1},
      {12'h800, 14'h10, 32'h0, 32'h100A0020, 32'h40200000, 2'd1},
      {12'h800, 14'h10, 32'h0, 32'h100A0021, 32'h00210000, 2'd1},
      {12'h800, 14'h0, 32'hBCDE0000, 32'h100B0000, 32'h7CDE0000, 2'd1},
      {12'h800, 14'h0, 32'h7CDE0000, 32'h100B0000, 32'h3CDE0000, 2'd1},
      {12'h800, 14'h0, 32'h12000045, 32'h100C0000, 32'h52450000, 2'd1},
      {12'h800, 14'h2A77, 32'h960000, 32'h100D0000, 32'h6A960000, 2'd1},
      {12'h800, 14'h2A77, 32'h3C, 32'h100E0000, 32'h6A3C0000, 2'd1},
      {12'h800, 14'h2A77, 32'h960000, 32'h100F0000, 32'h6A960000, 2'd1},
      {12'h800, 14'h2A77, 32'h3C, 32'h10100000, 32'h6A3C0000, 2'd1},
      {12'h900, 14'h0, 32'h0, 32'h101100F0, 32'h41F0, 2'd0},
      {12'h800, 14'h0, 32'h0, 32'h101100F0, 32'h40F0, 2'd0},
      {12'h800, 14'h0, 32'h0, 32'h101F0000, 32'h0, 2'd2}};
   localparam logic [31:0] MASKS [3] = '{32'h7FFF, 32'h7FFF4000, 32'h7FFF7FFF};
   localparam logic [15:0] VALID_PORTS = 16'h036F;
   logic        clk_i;
   logic        srst_i;
   logic [4:0]  address;
   logic        read;
   logic        write;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic [3:0]  be;
   logic        waitreq;
   logic [11:0] dmem_addr;
   logic [1:0]  dmem_bit;
   logic        dmem_ok;
   logic [13:0] pmem_addr;
   logic        pmem_ok;
   logic [1:0]  skip;
   logic        port_ok;
   logic        stack_bank;
   logic        legacy;
   logic [31:0] res_pins;
   logic [31:0] aux_pins;
   logic [31:0] q;
   logic [31:0] exp_aux;
   oag_row_t    r;
   int          n_fail;
   int          n_tests;
   // Result ports packed like the read-only words
   assign res_pins = {1'b0, pmem_ok, pmem_addr, 1'b0, dmem_ok, dmem_bit, dmem_addr};
   assign aux_pins = {26'h0, stack_bank, port_ok, 2'b00, skip};
   // Clock and devices
   always #50 clk_i = ~clk_i;
   oag_operand_address_gen u_oag_operand_address_gen (.clk_i(clk_i), .srst_i(srst_i),
      .avs_address_i(address), .avs_read_i(read), .avs_write_i(write),
      .avs_writedata_i(wdata), .avs_byteenable_i(be), .avs_readdata_o(rdata),
      .avs_waitrequest_o(waitreq), .dmem_addr_o(dmem_addr), .dmem_bit_o(dmem_bit),
      .dmem_ok_o(dmem_ok), .pmem_addr_o(pmem_addr), .pmem_ok_o(pmem_ok),
      .skip_cycles_o(skip), .port_ok_o(port_ok), .stack_bank_o(stack_bank),
      .legacy_mode_o(legacy));
   oag_host u_host (.clk_i(clk_i), .wait_i(waitreq), .rdata_i(rdata), .addr_o(address),
      .rd_o(read), .wr_o(write), .wdata_o(wdata), .be_o(be));
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
      n_tests++;
      if ((got & msk) !== (exp & msk))
      begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      u_host.xfer(1'b1, a, d, 4'hF, q);
   endtask
   task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp, input logic [31:0] msk);
      u_host.xfer(1'b0, a, 32'h0, 4'hF, q);
      chk(q, exp, msk);
   endtask
   task automatic release_rst();
      repeat (10) @(posedge clk_i);
      srst_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic chk_reset();
      rd_chk(OFF_CTRL, 32'h800, '1);
      rd_chk(OFF_OP, 32'h0, '1);
      rd_chk(OFF_RES, 32'h4000, '1);
      rd_chk(OFF_AUX, 32'h11, '1);
      chk({31'h0, legacy}, 32'h1, '1);
   endtask
   task automatic wrap_up();
      if (n_fail == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Watchdog against a hung handshake
   initial
   begin
      repeat (20000) @(posedge clk_i);
      n_fail++;
      wrap_up();
   end
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      clk_i = 1'b0;
      srst_i = 1'b1;
      n_fail = 0;
      n_tests = 0;
      release_rst();
      chk_reset();
      foreach (ROWS[i])
      begin
         r = ROWS[i];
         wr(OFF_CTRL, {20'h0, r.ctl});
         wr(OFF_PC, {18'h0, r.pc});
         wr(OFF_REGS, r.rg);
         wr(OFF_OP, r.op);
         exp_aux = {26'h0, r.ctl[8], 1'b1, 2'b00, (r.op[29:28] == 2'h3) ? 2'h2 : 2'h1};
         rd_chk(OFF_RES, r.res, MASKS[r.m]);
         rd_chk(OFF_AUX, exp_aux, '1);
         chk(res_pins, r.res, MASKS[r.m]);
         chk(aux_pins, exp_aux, '1);
      end
      // Every port number
      for (int p = 0; p < 16; p++)
      begin
         wr(OFF_OP, {4'h1, p[3:0], 24'h0});
         rd_chk(OFF_AUX, {27'h0, VALID_PORTS[p], 4'h1}, '1);
      end
      // Partial write, read-only and unmapped places
      wr(OFF_CTRL, 32'h8F1);
      u_host.xfer(1'b1, OFF_CTRL, 32'h0, 4'h1, q);
      rd_chk(OFF_CTRL, 32'h800, '1);
      wr(OFF_RES, 32'hFFFFFFFF);
      rd_chk(OFF_RES, 32'h4000, '1);
      wr(5'h18, 32'hFFFFFFFF);
      rd_chk(5'h18, 32'h0, '1);
      // Reset in mid-run from the extended mode
      wr(OFF_CTRL, 32'h0);
      chk({31'h0, legacy}, 32'h0, '1);
      srst_i <= 1'b1;
      release_rst();
      chk_reset();
      wrap_up();
   end
endmodule
`default_nettype wire
